// >>> core/pidt_consts.svh
// constants for the processor identifier and topology block
// Function
// RULE1 - startup message starts fetch at derived address
// RULE2 - start-up code takes the init lock first
// RULE3 - start-up code copies memory type mapping
// RULE4 - protected mode, controller space strongly uncacheable
// RULE5 - bit 8 enables controller; error vector programmed
// RULE6 - each processor gets distinct save base
// RULE7 - bump count, release lock, halt, await init
// RULE8 - extended mode returns 32-bit identifier by register read
// RULE9 - legacy mode returns 8-bit local identifier
// RULE10 - initial identifier reported in feature bits 31:24
// RULE11 - topology leaf reports unique 32-bit identifier
// RULE12 - initial identifier splits into up to four fields
// RULE13 - bits 2:1 carry package number
// RULE14 - bits 4:3 carry cluster number when clustered
// RULE15 - bit 0 thread select, zero without threading
// RULE16 - older 4-bit form: socket 1:0, cluster 3:2
// RULE17 - identifiers aligned to topology field boundaries
// RULE18 - vector selects 4 KByte page below 1 MByte
// RULE19 - field widths fixed by build parameters
`ifndef PIDT_CONSTS_SVH
`define PIDT_CONSTS_SVH
// ==========================================
// field positions
`define PIDT_ENABLE_BIT 8
`define PIDT_THREAD_BIT 0
`define PIDT_PKG_LO 1
`define PIDT_CLU_LO 3
`define PIDT_OLD_CLU_LO 2
`define PIDT_INIT_ID_LO 24
`define PIDT_PAGE_SHIFT 12
// ==========================================
// reset values
`define PIDT_SVR_RST 32'h0000_00ff
`define PIDT_ERR_RST 32'h0001_0000
`define PIDT_START_RST 32'hffff_fff0
`endif

// >>> core/pidt_pkg.sv
// types for the processor identifier and topology block
package pidt_pkg;
   typedef enum logic [3:0] {
      PIDT_WAIT_START = 4'b0001,
      PIDT_RUN = 4'b0010,
      PIDT_HALTED = 4'b0100,
      PIDT_BOOT = 4'b1000
   } pidt_state_t;
   typedef enum logic [1:0] {
      PIDT_FMT_LEGACY8 = 2'h0,
      PIDT_FMT_OLD4 = 2'h1
   } pidt_fmt_t;
endpackage

// >>> core/pidt_id_compose.sv
// composes the aligned initial identifier from topology straps
`timescale 1ns/100ps
`default_nettype none
`include "pidt_consts.svh"
module pidt_id_compose
   import pidt_pkg::*;
(
   input wire logic [1:0] pkg_i,
   input wire logic [1:0] cluster_i,
   input wire logic thread_i,
   input wire logic threads_en_i,
   input wire logic clustered_i,
   input wire logic old_fmt_i,
   output logic [7:0] id_o
);
   always_comb begin
      id_o = 8'h00;
      if (old_fmt_i) begin
         // older 4-bit form, upper nibble stays zero
         id_o[`PIDT_PKG_LO-1 +: 2] = pkg_i; // [RULE16]
         if (clustered_i) begin
            id_o[`PIDT_OLD_CLU_LO +: 2] = cluster_i; // [RULE16]
         end
      end else begin
         // each field lands on its own boundary, never packed across [RULE17] [RULE12]
         id_o[`PIDT_THREAD_BIT] = threads_en_i & thread_i; // [RULE15]
         id_o[`PIDT_PKG_LO +: 2] = pkg_i; // [RULE13]
         if (clustered_i) begin
            id_o[`PIDT_CLU_LO +: 2] = cluster_i; // [RULE14]
         end
      end
   end
endmodule
`default_nettype wire

// >>> core/pidt_id_split.sv
// splits an identifier into thread, package and cluster fields
`timescale 1ns/100ps
`default_nettype none
`include "pidt_consts.svh"
module pidt_id_split
   import pidt_pkg::*;
(
   input wire logic [7:0] id_i,
   input wire logic old_fmt_i,
   output logic thread_o,
   output logic [1:0] pkg_o,
   output logic [1:0] cluster_o
);
   always_comb begin
      if (old_fmt_i) begin
         thread_o = 1'b0;
         pkg_o = id_i[1:0]; // [RULE16]
         cluster_o = id_i[`PIDT_OLD_CLU_LO +: 2]; // [RULE16]
      end else begin
         thread_o = id_i[`PIDT_THREAD_BIT]; // [RULE15]
         pkg_o = id_i[`PIDT_PKG_LO +: 2]; // [RULE13]
         cluster_o = id_i[`PIDT_CLU_LO +: 2]; // [RULE14]
      end
   end
endmodule
`default_nettype wire

// >>> core/pidt_core.sv
// processor start-up and identifier reporting block
`timescale 1ns/100ps
`default_nettype none
`include "pidt_consts.svh"
module pidt_core
   import pidt_pkg::*;
#(
   parameter bit THREADS_EN = 1'b1, // [RULE19]
   parameter bit CLUSTERED = 1'b0, // [RULE19]
   parameter bit OLD_FMT = 1'b0 // [RULE19]
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic is_boot_i,
   input wire logic [1:0] pkg_strap_i,
   input wire logic [1:0] cluster_strap_i,
   input wire logic thread_strap_i,
   input wire logic startup_msg_i,
   input wire logic [7:0] startup_vec_i,
   input wire logic init_msg_i,
   input wire logic halt_instr_i,
   input wire logic extended_id_mode_i,
   input wire logic id_wr_i,
   input wire logic [7:0] id_wdata_i,
   input wire logic svr_wr_i,
   input wire logic [31:0] svr_wdata_i,
   input wire logic err_wr_i,
   input wire logic [31:0] err_wdata_i,
   output logic fetch_start_o,
   output logic [31:0] fetch_addr_o,
   output logic running_o,
   output logic halted_o,
   output logic ctrl_enabled_o,
   output logic [7:0] err_vector_o,
   output logic [31:0] model_reg_id_o,
   output logic [7:0] local_id_o,
   output logic [7:0] feature_ebx_hi_o,
   output logic [31:0] topo_edx_o,
   output logic thread_o,
   output logic [1:0] pkg_o,
   output logic [1:0] cluster_o
);
   // ==========================================
   // identifier capture
   function automatic logic [31:0] page_addr(input logic [7:0] vec);
      page_addr = {12'h000, vec, 12'h000}; // [RULE18]
   endfunction

   logic [7:0] composed_id;
   logic [7:0] init_id_r;
   logic [7:0] local_id_r;
   logic captured_r;
   pidt_state_t state_r;
   logic [31:0] svr_r;
   logic [31:0] err_r;

   pidt_id_compose u_compose (
      .pkg_i(pkg_strap_i),
      .cluster_i(cluster_strap_i),
      .thread_i(thread_strap_i),
      .threads_en_i(THREADS_EN),
      .clustered_i(CLUSTERED),
      .old_fmt_i(OLD_FMT),
      .id_o(composed_id)
   );

   // straps are caught one clock after reset release, never inside reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         captured_r <= 1'b0;
         init_id_r <= 8'h00;
      end else if (!captured_r) begin
         captured_r <= 1'b1;
         init_id_r <= composed_id; // [RULE10]
      end
   end

   // local identifier is writable in legacy mode, so it may drift from the initial one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         local_id_r <= 8'h00;
      end else if (!captured_r) begin
         local_id_r <= composed_id;
      end else if (id_wr_i && !extended_id_mode_i) begin
         local_id_r <= id_wdata_i; // [RULE10]
      end
   end

   // ==========================================
   // controller enable and error entry
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         svr_r <= `PIDT_SVR_RST;
      end else if (svr_wr_i) begin
         svr_r <= svr_wdata_i; // [RULE5]
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         err_r <= `PIDT_ERR_RST;
      end else if (err_wr_i) begin
         err_r <= err_wdata_i; // [RULE5]
      end
   end

   assign ctrl_enabled_o = svr_r[`PIDT_ENABLE_BIT]; // [RULE5]
   assign err_vector_o = err_r[7:0];

   // ==========================================
   // start-up state machine
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= PIDT_WAIT_START;
      end else begin
         case (state_r)
            PIDT_WAIT_START: begin
               if (is_boot_i) begin
                  state_r <= PIDT_BOOT;
               end else if (startup_msg_i) begin
                  state_r <= PIDT_RUN; // [RULE1]
               end
            end
            PIDT_RUN: begin
               if (init_msg_i) begin
                  state_r <= PIDT_WAIT_START;
               end else if (halt_instr_i) begin
                  state_r <= PIDT_HALTED; // [RULE7]
               end
            end
            PIDT_HALTED: begin
               if (init_msg_i) begin
                  state_r <= PIDT_WAIT_START; // [RULE7]
               end
            end
            PIDT_BOOT: begin
               state_r <= PIDT_BOOT;
            end
            default: begin
               state_r <= PIDT_WAIT_START;
            end
         endcase
      end
   end

   // fetch address is registered with the pulse so both line up
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fetch_start_o <= 1'b0;
         fetch_addr_o <= `PIDT_START_RST;
      end else begin
         fetch_start_o <= 1'b0;
         if (state_r == PIDT_WAIT_START && !is_boot_i && startup_msg_i) begin
            fetch_start_o <= 1'b1; // [RULE1]
            fetch_addr_o <= page_addr(startup_vec_i); // [RULE1] [RULE18]
         end
      end
   end

   assign running_o = (state_r == PIDT_RUN) || (state_r == PIDT_BOOT);
   assign halted_o = (state_r == PIDT_HALTED);

   // ==========================================
   // identifier reporting
   always_comb begin
      model_reg_id_o = 32'h0000_0000;
      if (extended_id_mode_i) begin
         model_reg_id_o = {24'h00_0000, init_id_r}; // [RULE8]
      end
   end
   assign topo_edx_o = {24'h00_0000, init_id_r}; // [RULE11] [RULE8]
   assign local_id_o = extended_id_mode_i ? 8'h00 : local_id_r; // [RULE9]
   assign feature_ebx_hi_o = init_id_r; // [RULE10]

   pidt_id_split u_split (
      .id_i(init_id_r),
      .old_fmt_i(OLD_FMT),
      .thread_o(thread_o),
      .pkg_o(pkg_o),
      .cluster_o(cluster_o)
   );

   // ==========================================
   // checks
   sequence start_seen_s;
      state_r == PIDT_WAIT_START && !is_boot_i && startup_msg_i;
   endsequence

   property start_fetch_p;
      @(posedge clk_i) disable iff (rst_i)
      start_seen_s |=> fetch_start_o && fetch_addr_o == {12'h000, $past(startup_vec_i), 12'h000};
   endproperty
   start_fetch_a: assert property (start_fetch_p) else $error("start fetch wrong"); // [RULE1]

   fetch_only_start_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE18]
      fetch_start_o |-> fetch_addr_o[31:20] == 12'h000 && fetch_addr_o[11:0] == 12'h000)
      else $error("fetch address outside first megabyte");

   enable_bit_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
      svr_wr_i |=> ctrl_enabled_o == $past(svr_wdata_i[`PIDT_ENABLE_BIT]))
      else $error("enable not bit 8");

   ext_read_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
      extended_id_mode_i |-> model_reg_id_o == topo_edx_o) else $error("ext id mismatch");

   init_stable_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
      captured_r && $past(captured_r) |-> $stable(feature_ebx_hi_o))
      else $error("initial id changed");

   legacy_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE9]
      captured_r && id_wr_i && !extended_id_mode_i |=> local_id_o == $past(id_wdata_i))
      else $error("legacy id not written");

   thread_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE15]
      !OLD_FMT && $rose(captured_r)
      |-> init_id_r[`PIDT_THREAD_BIT] == (THREADS_EN && $past(thread_strap_i)))
      else $error("thread bit wrong");

   pkg_field_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE13]
      !OLD_FMT && captured_r |-> pkg_o == init_id_r[2:1]) else $error("package field wrong");

   upper_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE17]
      captured_r |-> init_id_r[7:5] == 3'h0) else $error("id not aligned");

   halt_init_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
      halted_o && init_msg_i |=> state_r == PIDT_WAIT_START) else $error("init not taken");

   // ==========================================
   // start-up order, register write and capture checks
   sequence halt_seen_s;
      state_r == PIDT_RUN && halt_instr_i && !init_msg_i;
   endsequence

   sequence run_init_s;
      state_r == PIDT_RUN && init_msg_i;
   endsequence

   fetch_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
      fetch_start_o |=> !fetch_start_o)
      else $error("fetch pulse too long");

   fetch_run_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
      fetch_start_o |-> running_o && !halted_o)
      else $error("fetch without run");

   start_run_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
      start_seen_s |=> running_o && !halted_o)
      else $error("start not taken");

   refuse_busy_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
      state_r != PIDT_WAIT_START |=> !fetch_start_o)
      else $error("start taken while busy");

   addr_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
      !fetch_start_o |-> $stable(fetch_addr_o))
      else $error("fetch address moved");

   boot_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
      state_r == PIDT_BOOT |-> !fetch_start_o)
      else $error("bootstrap fetched");

   boot_stay_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
      state_r == PIDT_BOOT |=> state_r == PIDT_BOOT)
      else $error("bootstrap left boot");

   halt_take_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
      halt_seen_s |=> halted_o)
      else $error("halt not taken");

   halt_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
      halted_o && !init_msg_i |=> halted_o)
      else $error("halt left early");

   run_init_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
      run_init_s |=> state_r == PIDT_WAIT_START)
      else $error("init from run not taken");

   err_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
      err_wr_i |=> err_vector_o == $past(err_wdata_i[7:0]))
      else $error("error vector not written");

   enable_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
      !svr_wr_i |=> $stable(ctrl_enabled_o))
      else $error("enable moved without write");

   ext_ignore_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE9]
      captured_r && id_wr_i && extended_id_mode_i |=> $stable(local_id_r))
      else $error("id written in extended mode");

   local_init_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
      $rose(captured_r) |-> local_id_r == init_id_r)
      else $error("local id not initial");

   capture_pkg_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE13]
      !OLD_FMT && $rose(captured_r) |-> init_id_r[`PIDT_PKG_LO +: 2] == $past(pkg_strap_i))
      else $error("package strap lost");

   capture_clu_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE14]
      !OLD_FMT && CLUSTERED && $rose(captured_r)
      |-> init_id_r[`PIDT_CLU_LO +: 2] == $past(cluster_strap_i))
      else $error("cluster strap lost");
endmodule
`default_nettype wire

// >>> testbench/pidt_peer_model.sv
// boot firmware and peer processor model that issues messages
`timescale 1ns/100ps
`default_nettype none
module pidt_peer_model (
   input wire logic clk_i,
   output logic startup_msg_o,
   output logic [7:0] startup_vec_o,
   output logic init_msg_o,
   output logic halt_instr_o
);
   initial begin
      startup_msg_o = 1'b0;
      startup_vec_o = 8'h5a;
      init_msg_o = 1'b0;
      halt_instr_o = 1'b0;
   end
   // vector is scrambled outside the pulse so stale values never match
   task automatic startup(input logic [7:0] vec);
      @(posedge clk_i);
      startup_msg_o <= 1'b1;
      startup_vec_o <= vec;
      @(posedge clk_i);
      startup_msg_o <= 1'b0;
      startup_vec_o <= ~vec;
   endtask
   // pulse: one-clock init message when init is set, else one-clock halt instruction
   task automatic pulse(input bit init);
      @(posedge clk_i);
      init_msg_o <= init;
      halt_instr_o <= !init;
      @(posedge clk_i);
      init_msg_o <= 1'b0;
      halt_instr_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> testbench/pidt_core_tb_top.sv
// self-checking bench for the start-up and identifier block
`timescale 1ns/100ps
`default_nettype none
module pidt_core_tb_top;
   import pidt_pkg::*;
   logic clk_i, rst_i, ext, id_wr, svr_wr, err_wr, thr, smsg, imsg, halt_instr, boot;
   logic fst, run, hld, cen, th_o;
   logic [1:0] pkg, clu, pk_o, cl_o;
   logic [7:0] id_wd, svec, ev, lid, febx, v;
   logic [31:0] svr_wd, err_wd, seed, fad, mrid, tedx;
   int num_errors = 0;
   int checks_done = 0;
   pidt_core #(.THREADS_EN(1'b1), .CLUSTERED(1'b1), .OLD_FMT(1'b0)) i_pidt_core (
      .clk_i(clk_i), .rst_i(rst_i), .is_boot_i(boot), .pkg_strap_i(pkg),
      .cluster_strap_i(clu), .thread_strap_i(thr), .startup_msg_i(smsg),
      .startup_vec_i(svec), .init_msg_i(imsg), .halt_instr_i(halt_instr),
      .extended_id_mode_i(ext), .id_wr_i(id_wr), .id_wdata_i(id_wd),
      .svr_wr_i(svr_wr), .svr_wdata_i(svr_wd), .err_wr_i(err_wr),
      .err_wdata_i(err_wd), .fetch_start_o(fst), .fetch_addr_o(fad),
      .running_o(run), .halted_o(hld), .ctrl_enabled_o(cen), .err_vector_o(ev),
      .model_reg_id_o(mrid), .local_id_o(lid), .feature_ebx_hi_o(febx),
      .topo_edx_o(tedx), .thread_o(th_o), .pkg_o(pk_o), .cluster_o(cl_o));
   pidt_peer_model i_pidt_peer_model (.clk_i(clk_i), .startup_msg_o(smsg),
      .startup_vec_o(svec), .init_msg_o(imsg), .halt_instr_o(halt_instr));
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // ====================
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [7:0] e_id();
      e_id = {3'h0, clu, pkg, thr};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // straps only settle once, so each new set needs a full reset
   task automatic do_reset(input logic x, input logic b);
      seed = lfsr(seed);
      @(posedge clk_i);
      rst_i <= 1'b1;
      ext <= x;
      boot <= b;
      {pkg, clu, thr} <= seed[4:0];
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
   endtask
   task automatic reg_wr(input int k, input logic [31:0] d);
      @(posedge clk_i);
      id_wr <= (k == 0);
      svr_wr <= (k == 1);
      err_wr <= (k == 2);
      id_wd <= d[7:0];
      svr_wd <= d;
      err_wd <= d;
      @(posedge clk_i);
      {id_wr, svr_wr, err_wr} <= 3'h0;
      @(posedge clk_i);
      #1;
   endtask
   // ====================
   // tests
   initial begin
      seed = 32'h50fbdbc3;
      {rst_i, thr, pkg, clu} = '1;
      {ext, id_wr, svr_wr, err_wr, boot} = '0;
      {id_wd, svr_wd, err_wd} = '0;
      for (int i = 0; i < 6; i++) begin
         do_reset(i[0], 1'b0);
         chk(febx, e_id(), "initial id");
         chk(tedx, e_id(), "topology id");
         chk({th_o, cl_o, pk_o}, {thr, clu, pkg}, "fields");
         chk(mrid, ext ? e_id() : 8'h00, "model reg id");
         chk(lid, ext ? 8'h00 : e_id(), "local id");
         chk(cen, 1'b0, "ctrl off at reset");
         chk(fad, 32'hffff_fff0, "reset address");
      end
      $display("identifier test done");
      do_reset(1'b0, 1'b0);
      reg_wr(0, {24'h0, ~e_id()});
      chk(lid, {24'h0, ~e_id()}, "local id write");
      chk(febx, e_id(), "initial id kept");
      reg_wr(1, 32'h0000_01ff);
      chk(cen, 1'b1, "ctrl enabled");
      reg_wr(1, 32'h0000_00ff);
      chk(cen, 1'b0, "ctrl disabled");
      reg_wr(2, seed);
      chk(ev, seed[7:0], "error vector");
      do_reset(1'b1, 1'b0);
      reg_wr(0, 32'h0000_00a5);
      chk(mrid, {24'h0, e_id()}, "ext id");
      @(posedge clk_i);
      ext <= 1'b0;
      @(posedge clk_i);
      #1;
      chk(lid, {24'h0, e_id()}, "ext write ignored");
      $display("register test done");
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : (i == 2) ? 8'hbd : seed[7:0];
         i_pidt_peer_model.startup(v);
         #1;
         chk({fst, run}, 2'h3, "fetch pulse");
         chk(fad, {12'h0, v, 12'h000}, "start address");
         i_pidt_peer_model.startup(~v);
         #1;
         chk(fst, 1'b0, "refused in run");
         chk(fad, {12'h0, v, 12'h000}, "address kept in run");
         i_pidt_peer_model.pulse(1'b0);
         #1;
         chk({run, hld}, 2'h1, "halted");
         i_pidt_peer_model.startup(v);
         #1;
         chk({fst, hld}, 2'h1, "refused in halt");
         i_pidt_peer_model.pulse(1'b1);
         #1;
         chk({run, hld}, 2'h0, "back to wait");
      end
      i_pidt_peer_model.startup(v);
      i_pidt_peer_model.pulse(1'b1);
      #1;
      chk({run, hld}, 2'h0, "init from run");
      $display("start-up test done");
      do_reset(1'b0, 1'b1);
      i_pidt_peer_model.startup(8'hbd);
      #1;
      chk({fst, run}, 2'h1, "boot ignores start");
      chk(fad, 32'hffff_fff0, "boot keeps reset address");
      $display("boot test done");
      results();
   end
   initial begin
      #50000;
      num_errors++;
      results();
   end
endmodule
`default_nettype wire
